/* rtl/bolc_core.v */
`include "bolc_regs.vh"

// What this block does
// - read bursts wrap within sixteen, halves swap
// - column low bits always taken as zero
// - read start on any four-beat boundary
// - write bursts run sequentially from a sixteen-aligned word
// - sixteen-beat writes align to sixteen beats
// - thirty-two-beat writes align to thirty-two
// - write may start in upper half
// - read latency table without inversion, delay table
// - read latency table with inversion enabled
// - write latency set A table
// - write latency set B table
// - bit six picks write latency set
// - leveling bit holds device in mode-write state
// - mode write updates write-selected setpoint copy
// - latency outputs use operate-selected setpoint copy only; leveling takes written data directly
// - write-only register read toggles strobe, undefined data
module bolc_core (
	// system
	input  wire        clk,
	input  wire        sys_rst,
	// link clock from controller, sampled
	input  wire        link_ck,
	// command strobes and fields from the link side, sampled
	input  wire        mode_write_command,
	input  wire        mode_read_command,
	input  wire [5:0]  mode_addr,
	input  wire [7:0]  mode_data,
	input  wire        setpoint_write_select,
	input  wire        setpoint_operate_select,
	input  wire        read_inversion,
	input  wire        burst_start,
	input  wire        burst_is_write,
	input  wire        burst_beats_32,
	input  wire [4:0]  column_bits,
	// beat address stream out
	output wire        beat_valid,
	input  wire        beat_ready,
	output wire [4:0]  beat_word,
	output wire        burst_busy,
	// latency, leveling and mode-read outputs
	output reg  [5:0]  read_latency,
	output reg  [5:0]  write_latency,
	output reg  [4:0]  read_to_precharge_delay,
	output reg         write_leveling_active,
	output reg         mode_read_strobe,
	output reg  [7:0]  mode_read_data
);

// ****************************************
// functions
// ****************************************
function [5:0] rl_lookup;
	input [2:0] code;
	input       inv;
	begin
		case ({inv, code})
			4'h0: rl_lookup = 6'h06;
			4'h1: rl_lookup = 6'h0a;
			4'h2: rl_lookup = 6'h0e;
			4'h3: rl_lookup = 6'h14;
			4'h4: rl_lookup = 6'h18;
			4'h5: rl_lookup = 6'h1c;
			4'h6: rl_lookup = 6'h20;
			4'h7: rl_lookup = 6'h24;
			4'h8: rl_lookup = 6'h06;
			4'h9: rl_lookup = 6'h0c;
			4'ha: rl_lookup = 6'h10;
			4'hb: rl_lookup = 6'h16;
			4'hc: rl_lookup = 6'h1c;
			4'hd: rl_lookup = 6'h20;
			4'he: rl_lookup = 6'h24;
			default: rl_lookup = 6'h28;
		endcase
	end
endfunction

function [5:0] wl_lookup;
	input [2:0] code;
	input       set_b;
	begin
		case ({set_b, code})
			4'h0: wl_lookup = 6'h04;
			4'h1: wl_lookup = 6'h06;
			4'h2: wl_lookup = 6'h08;
			4'h3: wl_lookup = 6'h0a;
			4'h4: wl_lookup = 6'h0c;
			4'h5: wl_lookup = 6'h0e;
			4'h6: wl_lookup = 6'h10;
			4'h7: wl_lookup = 6'h12;
			4'h8: wl_lookup = 6'h04;
			4'h9: wl_lookup = 6'h08;
			4'ha: wl_lookup = 6'h0c;
			4'hb: wl_lookup = 6'h12;
			4'hc: wl_lookup = 6'h16;
			4'hd: wl_lookup = 6'h1a;
			4'he: wl_lookup = 6'h1e;
			default: wl_lookup = 6'h22;
		endcase
	end
endfunction

function [4:0] rtp_lookup;
	input [2:0] code;
	begin
		case (code)
			3'h4: rtp_lookup = 5'h0a;
			3'h5: rtp_lookup = 5'h0c;
			3'h6: rtp_lookup = 5'h0e;
			3'h7: rtp_lookup = 5'h10;
			default: rtp_lookup = 5'h08;
		endcase
	end
endfunction

// ****************************************
// input synchronisers
// ****************************************
// all link-side inputs cross together; controller holds them a link period
// limitation: a word skewed across the sample edge is only safe when held
reg  [27:0] sync_a;
reg  [27:0] sync_b;
reg         ck_prev;
wire [27:0] raw_in = {
	link_ck,
	mode_write_command,
	mode_read_command,
	mode_addr,
	mode_data,
	setpoint_write_select,
	setpoint_operate_select,
	read_inversion,
	burst_start,
	burst_is_write,
	burst_beats_32,
	column_bits
};

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		sync_a  <= 28'h0;
		sync_b  <= 28'h0;
		ck_prev <= 1'b0;
	end
	else
	begin
		sync_a  <= raw_in;
		sync_b  <= sync_a;
		ck_prev <= sync_b[27];
	end
end

// ****************************************
// decode of the synchronised word
// ****************************************
// strobes count only on a link rise, so a held level acts once
wire       ck_rise  = sync_b[27] & ~ck_prev;
wire       s_mrw    = sync_b[26] & ck_rise;
wire       s_mrr    = sync_b[25] & ck_rise;
wire [5:0] s_addr   = sync_b[24:19];
wire [7:0] s_data   = sync_b[18:11];
wire       s_setpoint_write_select = sync_b[10];
wire       s_setpoint_operate_select = sync_b[9];
wire       s_inv    = sync_b[8];
wire       s_start  = sync_b[7] & ck_rise;
wire       s_write  = sync_b[6];
wire       s_bl32   = sync_b[5];
wire [4:0] s_col    = sync_b[4:0];

// ****************************************
// latency configuration, two setpoints
// ****************************************
reg  [7:0] latency_config [0:1];
wire [7:0] active_cfg = latency_config[s_setpoint_operate_select];
wire       hit_cfg    = s_addr == `BOLC_LATENCY_CONFIG_ADDR;

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		latency_config[0]       <= `BOLC_LATENCY_CONFIG_RESET;
		latency_config[1]       <= `BOLC_LATENCY_CONFIG_RESET;
		write_leveling_active   <= 1'b0;
		read_latency            <= 6'h06;
		write_latency           <= 6'h04;
		read_to_precharge_delay <= 5'h08;
		mode_read_strobe        <= 1'b0;
		mode_read_data          <= 8'h00;
	end
	else
	begin
		if (s_mrw && hit_cfg)
		begin
			latency_config[s_setpoint_write_select] <= s_data;
			write_leveling_active    <= s_data[`BOLC_WRLEV_BIT];
		end
		read_latency <= rl_lookup(active_cfg[`BOLC_RL_LSB +: 3], s_inv);
		write_latency <= wl_lookup(active_cfg[`BOLC_WL_LSB +: 3],
			active_cfg[`BOLC_WLS_BIT]);
		read_to_precharge_delay <= rtp_lookup(active_cfg[`BOLC_RL_LSB +: 3]);
		// write-only: strobe toggles, data meaningless (zero here)
		mode_read_strobe <= s_mrr;
		mode_read_data   <= 8'h00;
	end
end

// ****************************************
// burst sequencer
// ****************************************
reg  [4:0] start_col;
reg  [4:0] beat_cnt;
reg        seq_32;
reg        seq_run;
wire       buf_in_ready;
wire [5:0] last_beat = seq_32 ? (`BOLC_BEATS_32 - 6'h1) : (`BOLC_BEATS_16 - 6'h1);
// low nibble wraps mod 16, bit 4 flips after sixteen beats
wire [3:0] lo_word   = start_col[3:0] + beat_cnt[3:0];
wire [4:0] cur_word  = {start_col[4] ^ beat_cnt[4], lo_word};

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		start_col <= 5'h00;
		beat_cnt  <= 5'h00;
		seq_32    <= 1'b0;
		seq_run   <= 1'b0;
	end
	else if (!seq_run)
	begin
		// mode-write state blocks bursts while leveling
		if (s_start && !write_leveling_active)
		begin
			seq_run  <= 1'b1;
			seq_32   <= s_bl32;
			beat_cnt <= 5'h00;
			// low bits forced zero: four-beat aligned start
			if (!s_write)
				start_col <= {s_col[4:2], 2'b00};
			else if (s_bl32)
				start_col <= 5'h00;
			else
				start_col <= {s_col[4], 4'h0};
		end
	end
	else if (buf_in_ready)
	begin
		beat_cnt <= beat_cnt + 5'h1;
		if ({1'b0, beat_cnt} == last_beat)
			seq_run <= 1'b0;
	end
end

assign burst_busy = seq_run;

// ****************************************
// two-entry output buffer
// ****************************************
// stall by receiver holds sequencer, no word lost
reg [4:0] buf_mem [0:1];
reg       wr_ptr;
reg       rd_ptr;
reg [1:0] count;
wire      push = seq_run & buf_in_ready;
wire      pop  = beat_valid & beat_ready;

assign buf_in_ready = count != 2'h2;
assign beat_valid   = count != 2'h0;
assign beat_word    = buf_mem[rd_ptr];

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		buf_mem[0] <= 5'h00;
		buf_mem[1] <= 5'h00;
		wr_ptr     <= 1'b0;
		rd_ptr     <= 1'b0;
		count      <= 2'h0;
	end
	else
	begin
		if (push)
		begin
			buf_mem[wr_ptr] <= cur_word;
			wr_ptr          <= ~wr_ptr;
		end
		if (pop)
			rd_ptr <= ~rd_ptr;
		count <= count + {1'b0, push} - {1'b0, pop};
	end
end

endmodule // bolc_core

/* rtl/bolc_regs.vh */
`ifndef BOLC_REGS_VH
`define BOLC_REGS_VH
// ****************************************
// register map
// ****************************************
`define BOLC_LATENCY_CONFIG_ADDR   6'h02
`define BOLC_LATENCY_CONFIG_RESET  8'h00
// ****************************************
// field positions
// ****************************************
`define BOLC_RL_LSB                3'h0
`define BOLC_WL_LSB                3'h3
`define BOLC_WLS_BIT               3'h6
`define BOLC_WRLEV_BIT             3'h7
// ****************************************
// burst lengths
// ****************************************
`define BOLC_BEATS_16              6'h10
`define BOLC_BEATS_32              6'h20
`define BOLC_ADDR_WORD_SLOTS       4'h4
`endif

/* verification/bolc_core_sva.sv */
module bolc_core_sva (
	// clock and reset
	input logic       clk,
	input logic       sys_rst,
	// beat stream
	input logic       beat_valid,
	input logic       beat_ready,
	input logic [4:0] beat_word,
	input logic       burst_busy,
	// latency, leveling and mode-read state
	input logic [5:0] read_latency,
	input logic [5:0] write_latency,
	input logic [4:0] read_to_precharge_delay,
	input logic       write_leveling_active,
	input logic       mode_read_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// stream, latency, strobe and leveling checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_HOLD: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat_word))
		else $error("stalled beat moved");
	AST_RLV: assert property (read_latency inside {6, 10, 12, 14, 16, 20, 22, 24, 28, 32, 36, 40})
		else $error("bad read latency");
	AST_WLV: assert property (write_latency inside {4, 6, 8, 10, 12, 14, 16, 18, 22, 26, 30, 34})
		else $error("bad write latency");
	AST_RTP: assert property (read_latency < 24 |-> read_to_precharge_delay == 8)
		else $error("bad precharge delay");
	AST_RTPMAX: assert property (read_latency == 40 |-> read_to_precharge_delay == 16)
		else $error("bad precharge delay");
	AST_STB: assert property (mode_read_strobe |=> !mode_read_strobe)
		else $error("strobe too long");
	AST_RST: assert property ($fell(sys_rst) |-> read_latency == 6 && write_latency == 4)
		else $error("bad reset latency");
	AST_LEV: assert property ($past(write_leveling_active) |-> !$rose(burst_busy))
		else $error("burst during leveling");
	AST_BUSY: assert property ($rose(burst_busy) |-> ##[0:2] beat_valid)
		else $error("no first beat");
endmodule // bolc_core_sva

bind bolc_core bolc_core_sva chk_u (.*);

/* verification/bolc_ctl_model.sv */
module bolc_ctl_model (
	// framing
	input  wire logic frame,
	// link clock
	output logic      link_ck
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// link clock, still between frames
	// ****
	initial link_ck = 1'b0;
	always #100 link_ck = frame ? ~link_ck : 1'b0;
endmodule // bolc_ctl_model

/* verification/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, sys_rst, link_ck, frame, beat_ready, beat_valid, burst_busy;
	logic        mode_write_command, mode_read_command, burst_start, burst_is_write;
	logic        setpoint_write_select, setpoint_operate_select, read_inversion;
	logic        burst_beats_32, write_leveling_active, mode_read_strobe;
	logic [5:0]  mode_addr, read_latency, write_latency;
	logic [7:0]  mode_data, mode_read_data;
	logic [4:0]  column_bits, beat_word, read_to_precharge_delay;
	logic [15:0] lfsr;
	logic [4:0]  exp_q[$];
	int          fails, samples_checked, strobes;
	int          rl_tab[16] = '{6, 10, 14, 20, 24, 28, 32, 36, 6, 12, 16, 22, 28, 32, 36, 40};
	int          wl_tab[16] = '{4, 6, 8, 10, 12, 14, 16, 18, 4, 8, 12, 18, 22, 26, 30, 34};
	int          rtp_tab[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
	bolc_core dut_u (.*);
	bolc_ctl_model link_u (.frame(frame), .link_ck(link_ck));
	// ****
	// helpers
	// ****
	always #12.5 clk = ~clk;
	function automatic logic [15:0] step(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task check(logic [7:0] seen, logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			fails++;
			$display("mismatch %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task final_report;
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// random stalls by the receiver
	always @(posedge clk)
	begin
		#2 lfsr = step(lfsr);
		beat_ready = lfsr[0] | lfsr[3];
	end
	// negedge sampling avoids racing the buffer flops
	always @(negedge clk)
	begin
		if (beat_valid === 1'b1 && beat_ready === 1'b1)
			check(8'(beat_word), 8'(exp_q.size() > 0 ? exp_q.pop_front() : 5'h1f));
		if (mode_read_strobe === 1'b1)
			strobes++;
	end
	// inputs held from at least four edges before the link rise until after its fall
	task cmd(logic w, logic r, logic b, logic [5:0] a, logic [7:0] d, logic [4:0] c);
		@(posedge clk) #2;
		{mode_write_command, mode_read_command, burst_start} = {w, r, b};
		{mode_addr, mode_data, column_bits} = {a, d, c};
		repeat (4) @(posedge clk);
		#2 frame = 1'b1;
		@(negedge link_ck);
		@(posedge clk) #2;
		{frame, mode_write_command, mode_read_command, burst_start} = '0;
		repeat (4) @(posedge clk);
		#2;
	endtask
	task burst(logic w, logic l, logic [4:0] c);
		{burst_is_write, burst_beats_32} = {w, l};
		for (int i = 0; i < (l ? 32 : 16); i++)
			exp_q.push_back({(w & l) ? i[4] : c[4] ^ i[4], w ? i[3:0] : 4'(c[3:2] * 4 + i)});
		cmd(1'b0, 1'b0, 1'b1, 6'h00, 8'h00, c);
		for (int k = 0; k < 400 && (exp_q.size() > 0 || burst_busy !== 1'b0); k++)
			@(posedge clk);
		#2;
		check(8'(exp_q.size()), 8'h00);
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		{clk, frame, beat_ready, mode_write_command, mode_read_command, burst_start} = '0;
		{burst_is_write, burst_beats_32, setpoint_write_select, setpoint_operate_select} = '0;
		{read_inversion, mode_addr, mode_data, column_bits, fails, samples_checked, strobes} = '0;
		sys_rst = 1'b1;
		lfsr = 16'hf1e9;
		repeat (20) @(posedge clk);
		#2 sys_rst = 1'b0;
		check(8'(read_latency), 8'h06);
		check(8'(write_latency), 8'h04);
		for (int i = 0; i < 16; i++)
		begin
			read_inversion = i[3];
			cmd(1'b1, 1'b0, 1'b0, 6'h02, {1'b0, i[0] ^ i[3], i[2:0], i[2:0]}, 5'h00);
			check(8'(read_latency), 8'(rl_tab[i]));
			check(8'(write_latency), 8'(wl_tab[{i[0] ^ i[3], i[2:0]}]));
			check(8'(read_to_precharge_delay), 8'(rtp_tab[i[2:0]]));
		end
		setpoint_write_select = 1'b1;
		cmd(1'b1, 1'b0, 1'b0, 6'h02, 8'h49, 5'h00);
		check(8'(read_latency), 8'd40);
		setpoint_operate_select = 1'b1;
		cmd(1'b1, 1'b0, 1'b0, 6'h05, 8'h00, 5'h00);
		check(8'(read_latency), 8'd12);
		check(8'(write_latency), 8'd8);
		cmd(1'b1, 1'b0, 1'b0, 6'h02, 8'h80, 5'h00);
		check(8'(write_leveling_active), 8'h01);
		cmd(1'b0, 1'b0, 1'b1, 6'h00, 8'h00, 5'h00);
		check(8'(burst_busy), 8'h00);
		cmd(1'b1, 1'b0, 1'b0, 6'h02, 8'h00, 5'h00);
		check(8'(write_leveling_active), 8'h00);
		cmd(1'b0, 1'b1, 1'b0, 6'h02, 8'h00, 5'h00);
		check(8'(strobes), 8'h01);
		check(mode_read_data, 8'h00);
		for (int j = 0; j < 8; j++)
			burst(j[2], j[0], j[2] ? {lfsr[4] & ~j[0], 4'h0} : lfsr[4:0]);
		final_report;
	end
	initial
	begin
		#200000;
		fails++;
		final_report;
	end
endmodule // tb_top
